// *** aop_top.sv ***
// adc output pins: data, output clock, shared flag pair, calibration status
// ==========================================================================
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module aop_top #(
  parameter int DATA_W = aop_pkg::DATA_W,
  parameter int PP_LAT = aop_pkg::PP_LAT_DEF,
  parameter int CAL_CYCLES = aop_pkg::CAL_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RESET_PIN_N,
  input wire logic SAMPLE_CLK,
  input wire logic ADDR_SEL_LOW,
  input wire logic [DATA_W-1:0] CORE_DATA,
  input wire logic CORE_OVR,
  input wire logic CORE_IQ_I,
  input wire logic [aop_pkg::ADDR_W-1:0] ADDR,
  input wire logic [aop_pkg::REG_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [aop_pkg::REG_W-1:0] RDATA,
  output logic [DATA_W-1:0] Q,
  output logic DATA_OUTPUT_CLOCK_P,
  output logic DATA_OUTPUT_CLOCK_N,
  output logic FLAG_P,
  output logic FLAG_N,
  output logic CAL_DONE,
  output logic IRQ
);
  localparam int CW = $clog2(CAL_CYCLES + 1);
  localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);

  // ========================================================================
  // pin synchronisers
  logic [2:0] s1;
  logic [2:0] s2;
  logic sclk_d;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      sclk_d <= 1'b0;
    end else begin
      s1 <= {ADDR_SEL_LOW, SAMPLE_CLK, RESET_PIN_N};
      s2 <= s1;
      sclk_d <= s2[1];
    end
  end
  logic hw_rst;
  logic rise;
  logic fall;
  assign hw_rst = !s2[0];
  assign rise = s2[1] && !sclk_d;
  assign fall = !s2[1] && sclk_d;

  function automatic logic hit(input logic [aop_pkg::ADDR_W-1:0] a,
                               input logic [aop_pkg::IDX_W-1:0] idx);
    hit = a[aop_pkg::ADDR_W-1:2] == idx;
  endfunction

  // ========================================================================
  // register file
  logic pp_en, cphs, dpol, fpol, lphs, srst;
  logic [aop_pkg::OMODE_W-1:0] omode;
  logic [aop_pkg::CTRL_W-1:0] ctrl;
  logic [aop_pkg::IRQ_W-1:0] ien, istat, events;
  logic next_pp_en, next_cphs, next_dpol, next_fpol, next_lphs, next_srst;
  logic [aop_pkg::OMODE_W-1:0] next_omode;
  logic [aop_pkg::CTRL_W-1:0] next_ctrl;
  logic [aop_pkg::IRQ_W-1:0] next_ien, next_istat, clr;
  logic [aop_pkg::REG_W-1:0] next_rdata;
  aop_pkg::aop_cal_t cal_state, next_cal_state;
  logic [CW-1:0] cal_cnt, next_cal_cnt;
  logic lvds, iq, idle;
  assign lvds = ctrl[aop_pkg::CTRL_LVDS];
  assign iq = ctrl[aop_pkg::CTRL_IQ];
  assign idle = ctrl[aop_pkg::CTRL_STBY] || ctrl[aop_pkg::CTRL_SHDN];

  always_comb begin
    next_pp_en = pp_en;
    next_cphs = cphs;
    next_dpol = dpol;
    next_fpol = fpol;
    next_lphs = lphs;
    next_omode = omode;
    next_ctrl = ctrl;
    next_ien = ien;
    next_srst = 1'b0;
    clr = aop_pkg::RST_IRQ;
    if (WR) begin
      if (hit(ADDR, aop_pkg::IDX_PP)) next_pp_en = WDATA[0];
      if (hit(ADDR, aop_pkg::IDX_OMODE)) begin
        next_omode = WDATA[aop_pkg::OMODE_W-1:0];
      end
      if (hit(ADDR, aop_pkg::IDX_CPHS)) next_cphs = WDATA[0];
      if (hit(ADDR, aop_pkg::IDX_LPHS)) next_lphs = WDATA[0];
      if (hit(ADDR, aop_pkg::IDX_DPOL)) next_dpol = WDATA[0];
      if (hit(ADDR, aop_pkg::IDX_FPOL)) next_fpol = WDATA[0];
      if (hit(ADDR, aop_pkg::IDX_CTRL)) begin
        next_ctrl = WDATA[aop_pkg::CTRL_W-1:0];
        next_srst = WDATA[aop_pkg::CTRL_SRST];
      end
      if (hit(ADDR, aop_pkg::IDX_IEN)) next_ien = WDATA[aop_pkg::IRQ_W-1:0];
      if (hit(ADDR, aop_pkg::IDX_ICLR)) clr = WDATA[aop_pkg::IRQ_W-1:0];
    end
    // set wins over clear so no event is lost
    next_istat = (istat & ~clr) | events;
    if (hw_rst) begin
      next_pp_en = aop_pkg::RST_BIT;
      next_cphs = aop_pkg::RST_BIT;
      next_dpol = aop_pkg::RST_BIT;
      next_fpol = aop_pkg::RST_BIT;
      next_lphs = aop_pkg::RST_BIT;
      next_omode = aop_pkg::ORDER_EVEN;
      next_ctrl = aop_pkg::RST_CTRL;
      next_ien = aop_pkg::RST_IRQ;
      next_istat = aop_pkg::RST_IRQ;
      next_srst = 1'b0;
    end
    next_rdata = '0;
    if (RD) begin
      if (hit(ADDR, aop_pkg::IDX_PP)) next_rdata[0] = pp_en;
      if (hit(ADDR, aop_pkg::IDX_OMODE)) begin
        next_rdata[aop_pkg::OMODE_W-1:0] = omode;
      end
      if (hit(ADDR, aop_pkg::IDX_CPHS)) next_rdata[0] = cphs;
      if (hit(ADDR, aop_pkg::IDX_LPHS)) next_rdata[0] = lphs;
      if (hit(ADDR, aop_pkg::IDX_DPOL)) next_rdata[0] = dpol;
      if (hit(ADDR, aop_pkg::IDX_FPOL)) next_rdata[0] = fpol;
      if (hit(ADDR, aop_pkg::IDX_CTRL)) begin
        next_rdata[aop_pkg::CTRL_W-1:0] = ctrl;
      end
      if (hit(ADDR, aop_pkg::IDX_STAT)) begin
        next_rdata[aop_pkg::STAT_CAL] = cal_state == aop_pkg::CAL_DONE;
        next_rdata[aop_pkg::STAT_RUN] = cal_state == aop_pkg::CAL_RUN;
        // chip address seen by the serial port, upper bit fixed
        next_rdata[aop_pkg::STAT_ADR] = s2[2];
        next_rdata[aop_pkg::STAT_ADR+1] = aop_pkg::ADDR_HIGH_FIXED;
      end
      if (hit(ADDR, aop_pkg::IDX_ISTAT)) begin
        next_rdata[aop_pkg::IRQ_W-1:0] = istat;
      end
      if (hit(ADDR, aop_pkg::IDX_IEN)) next_rdata[aop_pkg::IRQ_W-1:0] = ien;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pp_en <= aop_pkg::RST_BIT;
      cphs <= aop_pkg::RST_BIT;
      dpol <= aop_pkg::RST_BIT;
      fpol <= aop_pkg::RST_BIT;
      lphs <= aop_pkg::RST_BIT;
      srst <= 1'b0;
      omode <= aop_pkg::ORDER_EVEN;
      ctrl <= aop_pkg::RST_CTRL;
      ien <= aop_pkg::RST_IRQ;
      istat <= aop_pkg::RST_IRQ;
      RDATA <= '0;
      IRQ <= 1'b0;
    end else begin
      pp_en <= next_pp_en;
      cphs <= next_cphs;
      dpol <= next_dpol;
      fpol <= next_fpol;
      lphs <= next_lphs;
      srst <= next_srst;
      omode <= next_omode;
      ctrl <= next_ctrl;
      ien <= next_ien;
      istat <= next_istat;
      RDATA <= next_rdata;
      IRQ <= |(next_istat & next_ien);
    end
  end

  // ========================================================================
  // calibration sequencer; counter freezes in standby and shutdown
  logic cal_ev, next_cal_done;
  always_comb begin
    next_cal_state = cal_state;
    next_cal_cnt = cal_cnt;
    cal_ev = 1'b0;
    if (hw_rst) begin
      next_cal_state = aop_pkg::CAL_IDLE;
      next_cal_cnt = '0;
    end else if (srst) begin
      next_cal_state = aop_pkg::CAL_RUN;
      next_cal_cnt = '0;
    end else begin
      unique case (cal_state)
        aop_pkg::CAL_IDLE: begin
          next_cal_state = aop_pkg::CAL_RUN;
        end
        aop_pkg::CAL_RUN: begin
          if (!idle) begin
            next_cal_cnt = cal_cnt + CW'(1);
            if (cal_cnt == CAL_LAST) begin
              next_cal_state = aop_pkg::CAL_DONE;
              cal_ev = 1'b1;
            end
          end
        end
        aop_pkg::CAL_DONE: begin
          next_cal_state = aop_pkg::CAL_DONE;
        end
        default: begin
          next_cal_state = aop_pkg::CAL_IDLE;
        end
      endcase
    end
    // pin freezes in standby, even across a soft reset restart
    next_cal_done = (idle && !hw_rst) ? CAL_DONE
                  : next_cal_state == aop_pkg::CAL_DONE;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cal_state <= aop_pkg::CAL_IDLE;
      cal_cnt <= '0;
      CAL_DONE <= 1'b0;
    end else begin
      cal_state <= next_cal_state;
      cal_cnt <= next_cal_cnt;
      CAL_DONE <= next_cal_done;
    end
  end

  // ========================================================================
  // output datapath
  function automatic logic [DATA_W-1:0] pairs(input logic [DATA_W-1:0] d,
                                              input logic odd);
    logic [DATA_W-1:0] p;
    p = '0;
    for (int k = 0; k < DATA_W / 2; k++) begin
      p[2*k+1] = odd ? d[2*k+1] : d[2*k];
      p[2*k] = !p[2*k+1];
    end
    pairs = p;
  endfunction

  aop_pkg::aop_word_t dly [PP_LAT];
  aop_pkg::aop_word_t next_dly [PP_LAT];
  aop_pkg::aop_word_t in_w, sel_w, hold, next_hold;
  logic active, odd_first, inv;
  logic [DATA_W-1:0] next_q, pol;
  logic next_data_output_clock, next_fp, next_fn;
  logic data_output_clock_lvl, next_data_output_clock_lvl;
  assign in_w = '{overrange_flag: CORE_OVR, iq_i: CORE_IQ_I, data: CORE_DATA};
  // post-processing delays data but never the overrange flag
  assign sel_w = pp_en ? dly[PP_LAT-1] : in_w;
  assign active = !hw_rst && !idle;
  assign odd_first = omode == aop_pkg::ORDER_ODD;
  assign inv = lvds ? lphs : cphs;
  assign pol = {DATA_W{dpol}};

  always_comb begin
    next_dly = dly;
    next_hold = hold;
    next_q = Q;
    next_data_output_clock_lvl = data_output_clock_lvl;
    next_fp = FLAG_P;
    next_fn = FLAG_N;
    if (active && rise) begin
      next_dly[0] = in_w;
      for (int i = 1; i < PP_LAT; i++) next_dly[i] = dly[i-1];
      next_hold = '{overrange_flag: CORE_OVR, iq_i: sel_w.iq_i, data: sel_w.data};
      next_data_output_clock_lvl = 1'b1;
      next_q = lvds ? pairs(sel_w.data ^ pol, odd_first)
                    : sel_w.data ^ pol;
      next_fp = CORE_OVR ^ fpol;
      next_fn = iq ? (lvds ? !(CORE_OVR ^ fpol) : sel_w.iq_i ^ fpol)
                   : 1'b0;
    end else if (active && fall) begin
      next_data_output_clock_lvl = 1'b0;
      if (lvds) begin
        next_q = pairs(hold.data ^ pol, !odd_first);
        if (iq) begin
          next_fp = hold.iq_i ^ fpol;
          next_fn = !(hold.iq_i ^ fpol);
        end
      end
    end
    if (!iq) next_fn = 1'b0;
    if (hw_rst) begin
      next_q = '0;
      next_data_output_clock_lvl = 1'b0;
      next_fp = 1'b0;
      next_fn = 1'b0;
    end
    next_data_output_clock = next_data_output_clock_lvl ^ inv;
  end
  assign events = {active && rise && CORE_OVR, cal_ev};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < PP_LAT; i++) dly[i] <= '0;
      hold <= '0;
      data_output_clock_lvl <= 1'b0;
      Q <= '0;
      DATA_OUTPUT_CLOCK_P <= 1'b0;
      DATA_OUTPUT_CLOCK_N <= 1'b1;
      FLAG_P <= 1'b0;
      FLAG_N <= 1'b0;
    end else begin
      dly <= next_dly;
      hold <= next_hold;
      data_output_clock_lvl <= next_data_output_clock_lvl;
      Q <= next_q;
      DATA_OUTPUT_CLOCK_P <= next_data_output_clock;
      DATA_OUTPUT_CLOCK_N <= !next_data_output_clock;
      FLAG_P <= next_fp;
      FLAG_N <= next_fn;
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_lvds_plain;
    active && lvds && !dpol && !odd_first;
  endsequence
  a_cal_reset_low: assert property (hw_rst |=> !CAL_DONE)
    else $error("cal done not low in reset");
  a_cal_standby_hold: assert property (idle && !hw_rst
    |=> $stable(CAL_DONE))
    else $error("cal done moved in standby");
  a_cal_done_rise: assert property ($rose(CAL_DONE)
    |-> $past(cal_state) == aop_pkg::CAL_RUN && $past(cal_cnt) == CAL_LAST)
    else $error("cal done rose early");
  a_cal_start: assert property ($fell(hw_rst)
    |=> cal_state == aop_pkg::CAL_RUN ##1 !CAL_DONE)
    else $error("cal did not start after reset");
  a_reg_defaults: assert property (hw_rst
    |=> omode == aop_pkg::ORDER_EVEN && ctrl == aop_pkg::RST_CTRL)
    else $error("registers not at default");
  a_even_high_half: assert property (s_lvds_plain ##0 (rise && !pp_en)
    |=> Q[1] == $past(CORE_DATA[0]) && DATA_OUTPUT_CLOCK_P == !lphs)
    else $error("even bit not in high half");
  a_odd_low_half: assert property (s_lvds_plain ##0 fall
    |=> Q[1] == $past(hold.data[1]) && Q[0] == !Q[1])
    else $error("odd bit not in low half");
  a_ovr_early: assert property (active && rise && !fpol
    |=> FLAG_P == $past(CORE_OVR))
    else $error("overrange flag not current");
  a_neg_zero: assert property (!iq |=> !FLAG_N)
    else $error("negative flag pin not zero");
  a_wck_lvds: assert property (active && fall && lvds && iq && !fpol
    |=> FLAG_P == $past(hold.iq_i))
    else $error("word clock missing in low half");
  a_wck_cmos: assert property (active && rise && !lvds && iq && !fpol
    && !pp_en |=> FLAG_N == $past(CORE_IQ_I))
    else $error("word clock not with in-phase data");
endmodule
`default_nettype wire

// *** aop_pkg.sv ***
// shared constants and types for the adc output pin block
package aop_pkg;
  localparam int DATA_W = 12;
  localparam int ADDR_W = 10;
  localparam int REG_W = 32;
  localparam int IDX_W = 8;
  localparam int PP_LAT_DEF = 4;
  localparam int CAL_CYCLES_DEF = 1024;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PP = 8'h52;
  localparam logic [IDX_W-1:0] IDX_OMODE = 8'h62;
  localparam logic [IDX_W-1:0] IDX_CPHS = 8'h64;
  localparam logic [IDX_W-1:0] IDX_DPOL = 8'h65;
  localparam logic [IDX_W-1:0] IDX_FPOL = 8'h68;
  localparam logic [IDX_W-1:0] IDX_LPHS = 8'h6D;
  localparam logic [IDX_W-1:0] IDX_CTRL = 8'h70;
  localparam logic [IDX_W-1:0] IDX_STAT = 8'h71;
  localparam logic [IDX_W-1:0] IDX_ISTAT = 8'h72;
  localparam logic [IDX_W-1:0] IDX_IEN = 8'h73;
  localparam logic [IDX_W-1:0] IDX_ICLR = 8'h74;
  // field positions
  localparam int CTRL_LVDS = 0;
  localparam int CTRL_IQ = 1;
  localparam int CTRL_STBY = 2;
  localparam int CTRL_SHDN = 3;
  localparam int CTRL_SRST = 4;
  localparam int CTRL_W = 4;
  localparam int STAT_CAL = 0;
  localparam int STAT_RUN = 1;
  localparam int STAT_ADR = 2;
  localparam int IRQ_CAL = 0;
  localparam int IRQ_OVR = 1;
  localparam int IRQ_W = 2;
  localparam int OMODE_W = 2;
  // reset values, order codes and the fixed address bit
  localparam logic [OMODE_W-1:0] ORDER_EVEN = 2'h0;
  localparam logic [OMODE_W-1:0] ORDER_ODD = 2'h1;
  localparam logic [CTRL_W-1:0] RST_CTRL = 4'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
  localparam logic RST_BIT = 1'b0;
  localparam logic ADDR_HIGH_FIXED = 1'b0;

  typedef struct packed {
    logic overrange_flag;
    logic iq_i;
    logic [DATA_W-1:0] data;
  } aop_word_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01,
    CAL_DONE = 2'b10
  } aop_cal_t;
endpackage

// *** aop_rx_model.sv ***
// receiving logic model: captures the output pins at output clock edges
`timescale 1ns/10ps
`default_nettype none
module aop_rx_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lvds,
  input wire logic [aop_pkg::DATA_W-1:0] q,
  input wire logic data_output_clock_p,
  input wire logic flag_p,
  input wire logic flag_n,
  output logic [aop_pkg::DATA_W-1:0] word,
  output logic overrange_flag,
  output logic iq_word_clock,
  output logic fn,
  output int cnt
);
  // ========
  // capture
  // of the output clock pair only the positive pin is read; a real receiver
  // compares both, so a broken negative pin stays unseen here
  logic data_output_clock_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_output_clock_q <= 1'b0;
      word <= '0;
      overrange_flag <= 1'b0;
      iq_word_clock <= 1'b0;
      fn <= 1'b0;
      cnt <= 0;
    end else begin
      data_output_clock_q <= data_output_clock_p;
      if (data_output_clock_p && !data_output_clock_q) begin
        overrange_flag <= flag_p;
        fn <= flag_n;
        for (int k = 0; k < aop_pkg::DATA_W / 2; k++) begin
          word[2*k] <= lvds ? q[2*k+1] : q[2*k];
          word[2*k+1] <= lvds ? word[2*k+1] : q[2*k+1];
        end
      end
      if (!data_output_clock_p && data_output_clock_q) begin
        cnt <= cnt + 1;
        if (lvds) begin
          iq_word_clock <= flag_p;
          for (int k = 0; k < aop_pkg::DATA_W / 2; k++) begin
            word[2*k+1] <= q[2*k+1];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** adc_output_status_pins_test.sv ***
// self-checking bench for the adc output pin block
`timescale 1ns/10ps
`default_nettype none
module adc_output_status_pins_test;
  logic clk, rst_n, rpin_n, sclk, asel, c_ovr, c_iq, wr, rd, lvds;
  logic [aop_pkg::DATA_W-1:0] c_data, q, rx_word, qh;
  logic [aop_pkg::ADDR_W-1:0] addr;
  logic [aop_pkg::REG_W-1:0] wdata, rdata, v;
  logic data_output_clock_p, data_output_clock_n, flag_p, flag_n, cal_done, irq, rx_ovr, rx_wck, rx_fn;
  int rx_cnt, n_fail, comparisons;

  aop_top #(.PP_LAT(1), .CAL_CYCLES(8)) DUT (.CLK(clk), .RST_N(rst_n),
    .RESET_PIN_N(rpin_n), .SAMPLE_CLK(sclk), .ADDR_SEL_LOW(asel),
    .CORE_DATA(c_data), .CORE_OVR(c_ovr), .CORE_IQ_I(c_iq), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .Q(q),
    .DATA_OUTPUT_CLOCK_P(data_output_clock_p), .DATA_OUTPUT_CLOCK_N(data_output_clock_n), .FLAG_P(flag_p), .FLAG_N(flag_n),
    .CAL_DONE(cal_done), .IRQ(irq));
  aop_rx_model rx (.clk(clk), .rst_n(rst_n), .lvds(lvds), .q(q),
    .data_output_clock_p(data_output_clock_p), .flag_p(flag_p), .flag_n(flag_n), .word(rx_word),
    .overrange_flag(rx_ovr), .iq_word_clock(rx_wck), .fn(rx_fn), .cnt(rx_cnt));

  // ========
  // helpers
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] idx);
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_cal(input logic b);
    for (int n = 0; n < 60 && cal_done !== b; n++) tick(1);
  endtask
  // sample clock is unrelated in phase, so two boundaries must pass
  task automatic send(input logic [11:0] d, input logic o, i);
    int c0;
    @(posedge clk);
    c_data <= d;
    c_ovr <= o;
    c_iq <= i;
    c0 = rx_cnt;
    for (int n = 0; n < 100 && rx_cnt < c0 + 2; n++) tick(1);
  endtask

  // ========
  // scenarios
  task automatic t_reset();
    chk("cal_done", cal_done, 0);
    rd_reg(aop_pkg::IDX_STAT);
    chk("stat", v, 32'h0000_0004);
    @(posedge clk);
    rpin_n <= 1'b1;
    wait_cal(1'b1);
    chk("cal_done", cal_done, 1);
    rd_reg(aop_pkg::IDX_STAT);
    chk("stat", v, 32'h0000_0005);
    rd_reg(aop_pkg::IDX_OMODE);
    chk("omode", v, {30'h0, aop_pkg::ORDER_EVEN});
    rd_reg(8'h00);
    chk("unmapped", v, 0);
    rd_reg(aop_pkg::IDX_ISTAT);
    chk("istat", v, 32'h0000_0001);
    chk("irq", irq, 0);
    wr_reg(aop_pkg::IDX_IEN, 32'h0000_0003);
    tick(2);
    chk("irq", irq, 1);
    wr_reg(aop_pkg::IDX_ICLR, 32'h0000_0001);
    tick(2);
    chk("irq", irq, 0);
  endtask
  task automatic t_cmos();
    send(12'hA5C, 1'b1, 1'b0);
    chk("word", rx_word, 12'hA5C);
    chk("ovr", rx_ovr, 1);
    chk("flag_n", rx_fn, 0);
    chk("data_output_clock_n", data_output_clock_n, !data_output_clock_p);
    chk("irq", irq, 1);
    send(12'h5A3, 1'b0, 1'b0);
    chk("ovr", rx_ovr, 0);
    wr_reg(aop_pkg::IDX_ICLR, 32'h0000_0002);
    tick(2);
    chk("irq", irq, 0);
    wr_reg(aop_pkg::IDX_DPOL, 32'h0000_0001);
    send(12'h0F3, 1'b0, 1'b0);
    chk("word", rx_word, 12'hF0C);
    wr_reg(aop_pkg::IDX_DPOL, 32'h0000_0000);
  endtask
  task automatic t_lvds();
    wr_reg(aop_pkg::IDX_CTRL, 32'h0000_0001);
    lvds <= 1'b1;
    send(12'h9B6, 1'b1, 1'b0);
    chk("word", rx_word, 12'h9B6);
    chk("ovr", rx_ovr, 1);
    chk("flag_n", rx_fn, 0);
    wr_reg(aop_pkg::IDX_OMODE, {30'h0, aop_pkg::ORDER_ODD});
    send(12'h9B6, 1'b1, 1'b0);
    chk("word odd", rx_word, 12'h679);
    wr_reg(aop_pkg::IDX_OMODE, {30'h0, aop_pkg::ORDER_EVEN});
    wr_reg(aop_pkg::IDX_CTRL, 32'h0000_0003);
    send(12'h3C1, 1'b0, 1'b1);
    chk("wck", rx_wck, 1);
    chk("ovr", rx_ovr, 0);
    send(12'h3C2, 1'b1, 1'b0);
    chk("wck", rx_wck, 0);
    chk("ovr", rx_ovr, 1);
    wr_reg(aop_pkg::IDX_CTRL, 32'h0000_0002);
    lvds <= 1'b0;
    send(12'h123, 1'b1, 1'b1);
    chk("flag_n", rx_fn, 1);
    chk("ovr", rx_ovr, 1);
    wr_reg(aop_pkg::IDX_CTRL, 32'h0000_0000);
  endtask
  task automatic t_pp();
    wr_reg(aop_pkg::IDX_PP, 32'h0000_0001);
    send(12'h6E1, 1'b1, 1'b0);
    @(posedge clk);
    c_data <= 12'h1E6;
    c_ovr <= 1'b0;
    for (int n = 0; n < 100 && rx_ovr !== 1'b0; n++) tick(1);
    chk("lag", rx_word, 12'h6E1);
    wr_reg(aop_pkg::IDX_PP, 32'h0000_0000);
  endtask
  task automatic t_stby();
    wr_reg(aop_pkg::IDX_CTRL, 32'h0000_0004);
    tick(4);
    qh = q;
    @(posedge clk);
    c_data <= ~qh;
    tick(40);
    chk("q hold", q, qh);
    chk("cal_done", cal_done, 1);
    wr_reg(aop_pkg::IDX_CTRL, 32'h0000_0014);
    tick(3);
    chk("cal_done", cal_done, 1);
    wr_reg(aop_pkg::IDX_CTRL, 32'h0000_0000);
    wr_reg(aop_pkg::IDX_CTRL, 32'h0000_0010);
    wait_cal(1'b0);
    chk("cal_done", cal_done, 0);
    wait_cal(1'b1);
    chk("cal_done", cal_done, 1);
    wr_reg(aop_pkg::IDX_OMODE, {30'h0, aop_pkg::ORDER_ODD});
    @(posedge clk);
    rpin_n <= 1'b0;
    tick(6);
    chk("cal_done", cal_done, 0);
    @(posedge clk);
    rpin_n <= 1'b1;
    rd_reg(aop_pkg::IDX_OMODE);
    chk("omode", v, {30'h0, aop_pkg::ORDER_EVEN});
    wait_cal(1'b1);
    chk("cal_done", cal_done, 1);
  endtask

  // ========
  // run control
  task automatic print_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // free-running sample clock, phase chosen off the system grid
  initial begin
    sclk = 1'b0;
    #1.3;
    forever #24 sclk = ~sclk;
  end
  initial begin
    #60000;
    n_fail++;
    print_verdict();
  end
  initial begin
    {rst_n, rpin_n, c_ovr, c_iq, wr, rd, lvds} = '0;
    asel = 1'b1;
    c_data = '0;
    addr = '0;
    wdata = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    tick(4);
    t_reset();
    t_cmos();
    t_lvds();
    t_pp();
    t_stby();
    print_verdict();
  end
endmodule
`default_nettype wire
